// [nand_host_regs.svh]
// What this block does
// - Program: 80H, three address bytes, data
// - Completion seen on ready line only, not bit6
// - Erase: 60H, two block bytes, D0H
// - Reissue read command after status read
// - 90H, address 00H, then two id reads
// - Keep write protect low around power-up
// - Main read: 00H plus three address bytes
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define REG_CMD    8'h00
`define REG_ADDR   8'h04
`define REG_WDATA  8'h08
`define REG_RDATA  8'h0c
`define REG_STATUS 8'h10
`define REG_CFG    8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define F_OP_MSB   2
`define F_LEN_MSB  15
`define F_LEN_LSB  4
`define SB_FAIL    0
`define SB_READY   6
`define SB_WPOFF   7

// ----------------------------------------------------------------
// Card command bytes
// ----------------------------------------------------------------
`define CMD_READ0     8'h00
`define CMD_SERIAL_IN 8'h80
`define CMD_PROG_GO   8'h10
`define CMD_ERASE_SET 8'h60
`define CMD_ERASE_GO  8'hd0
`define CMD_STATUS    8'h70
`define CMD_READ_ID   8'h90
`define CMD_RESET     8'hff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STATUS_RST 8'hc0
`define PINS_IDLE  15'h1c00

// ----------------------------------------------------------------
// Timing (ns as given, cycles derived at the clock rate)
// ----------------------------------------------------------------
`define CLK_MHZ     250
`define T_WP_NS     25
`define T_WH_NS     15
`define T_RP_NS     35
`define T_WB_NS     100
`define SYNC_STAGES 2
`define T_WP_CYC ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define T_WH_CYC ((`T_WH_NS * `CLK_MHZ + 999) / 1000)
`define T_RP_CYC ((`T_RP_NS * `CLK_MHZ + 999) / 1000)
`define T_WB_CYC ((`T_WB_NS * `CLK_MHZ + 999) / 1000)
`define RD_LOW_CYC (`T_RP_CYC + `SYNC_STAGES)

`endif

// [nand_host_pkg.sv]
package nand_host_pkg;

  // Kind of one strobed bus cycle
  typedef enum logic [1:0] {CK_CMD, CK_ADDR, CK_WDATA, CK_RDATA} cyc_kind_t;

  // One cycle request towards the card
  typedef struct packed {
    cyc_kind_t  kind;
    logic [7:0] data;
  } cyc_req_t;

  // Card-facing pins, all levels as driven on the wires
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       chipEnableLow;
    logic       writeStrobeLow;
    logic       readStrobeLow;
    logic       writeProtectLow;
    logic       ioOe;
    logic [7:0] ioOut;
  } nand_out_t;

  // Software operations
  typedef enum logic [2:0]
    {OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_ID, OP_RESET} op_kind_t;

  typedef enum logic [3:0]
    {S_IDLE, S_READY, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_WB, S_BUSY,
     S_STCMD, S_STRD, S_RDATA} op_state_t;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_LOW, C_HIGH} cyc_state_t;

  // Whole state of the cycle engine
  typedef struct packed {
    cyc_state_t st;
    logic [7:0] cnt;
    cyc_kind_t  kind;
    nand_out_t  pins;
    logic [7:0] ioMeta;
    logic [7:0] ioSync;
    logic [7:0] rdByte;
    logic       rdValid;
  } cyc_state_s_t;

  // Whole state of the host controller
  typedef struct packed {
    op_state_t  st;
    op_kind_t   op;
    logic [11:0] len;
    logic [11:0] cnt;
    logic [1:0] aIdx;
    logic [23:0] addr;
    logic [7:0] wByte;
    logic       wFull;
    logic [7:0] rByte;
    logic       rFull;
    logic       pend;
    logic [7:0] statusByte;
    logic [7:0] idMaker;
    logic [7:0] idDevice;
    logic       wpRelease;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] lastCmd;
    logic [1:0] addrSeen;
    logic       rbMeta;
    logic       rbSync;
  } host_state_t;

endpackage : nand_host_pkg

// [nand_cycle.sv]
`timescale 1ns/1ns
`default_nettype none
`include "nand_host_regs.svh"

module nand_cycle
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Request from the sequencer
  input  wire logic       reqValid,
  input  wire cyc_req_t   req,
  output logic            reqReady,
  input  wire logic       wpRelease,
  // Captured read byte
  output logic            rdValid,
  output logic [7:0]      rdByte,
  // Card pins
  output nand_out_t       pins,
  input  wire logic [7:0] ioIn
);

  cyc_state_s_t s_r;    // Registered state
  cyc_state_s_t s_nxt;  // Next state

  // ----------------------------------------------------------------
  // Strobe sequencing
  // ----------------------------------------------------------------
  // Setup phase puts CLE/ALE/data out a cycle before the strobe falls
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ioMeta = ioIn;
    s_nxt.ioSync = s_r.ioMeta;
    s_nxt.rdValid = 1'b0;
    s_nxt.pins.writeProtectLow = wpRelease;
    unique case (s_r.st)
      C_IDLE:
      begin
        if (reqValid)
        begin
          s_nxt.kind = req.kind;
          s_nxt.pins.chipEnableLow = 1'b0;
          s_nxt.pins.cle = (req.kind == CK_CMD);
          s_nxt.pins.ale = (req.kind == CK_ADDR);
          s_nxt.pins.ioOut = req.data;
          s_nxt.pins.ioOe = (req.kind != CK_RDATA);
          s_nxt.st = C_SETUP;
        end
      end
      C_SETUP:
      begin
        // Reads stay low longer: the pins pass a two-flop synchroniser
        if (s_r.kind == CK_RDATA)
        begin
          s_nxt.pins.readStrobeLow = 1'b0;
          s_nxt.cnt = 8'(`RD_LOW_CYC - 1);
        end
        else
        begin
          s_nxt.pins.writeStrobeLow = 1'b0;
          s_nxt.cnt = 8'(`T_WP_CYC - 1);
        end
        s_nxt.st = C_LOW;
      end
      C_LOW:
      begin
        if (s_r.cnt == 8'h00)
        begin
          // Rising strobe edge latches command, address or data
          if (s_r.kind == CK_RDATA)
          begin
            s_nxt.rdByte = s_r.ioSync;
            s_nxt.rdValid = 1'b1;
          end
          s_nxt.pins.readStrobeLow = 1'b1;
          s_nxt.pins.writeStrobeLow = 1'b1;
          s_nxt.cnt = 8'(`T_WH_CYC - 1);
          s_nxt.st = C_HIGH;
        end
        else
          s_nxt.cnt = s_r.cnt - 8'h01;
      end
      C_HIGH:
      begin
        if (s_r.cnt == 8'h00)
        begin
          s_nxt.pins.chipEnableLow = 1'b1;
          s_nxt.pins.cle = 1'b0;
          s_nxt.pins.ale = 1'b0;
          s_nxt.pins.ioOe = 1'b0;
          s_nxt.st = C_IDLE;
        end
        else
          s_nxt.cnt = s_r.cnt - 8'h01;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.pins <= `PINS_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign reqReady = (s_r.st == C_IDLE);
  assign rdValid = s_r.rdValid;
  assign rdByte = s_r.rdByte;
  assign pins = s_r.pins;

endmodule : nand_cycle
`default_nettype wire

// [nand_host.sv]
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "nand_host_regs.svh"

module nand_host
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Card pins
  output nand_out_t        nandOut,
  input  wire logic [7:0]  ioIn,
  input  wire logic        readyIn
);

  host_state_t s_r;     // Registered state
  host_state_t s_nxt;   // Next state
  logic        reqValid; // Cycle request offered
  cyc_req_t    req;      // Cycle request payload
  logic        reqReady; // Cycle engine idle
  logic        fire;     // Request taken
  logic        rdDone;   // Read byte captured
  logic [7:0]  rdByte;   // Captured byte
  logic        awTake;   // Write address and data taken
  logic        busy;     // Operation under way

  assign awTake = awvalid && wvalid && !s_r.bvalid;
  assign awready = awTake;
  assign wready = awTake;
  assign arready = !s_r.rvalid;
  assign fire = reqValid && reqReady;
  assign busy = (s_r.st != S_IDLE);

  // ----------------------------------------------------------------
  // Cycle request for the current state
  // ----------------------------------------------------------------
  always_comb
  begin
    reqValid = 1'b0;
    req.kind = CK_CMD;
    req.data = 8'h00;
    unique case (s_r.st)
      S_CMD1:
      begin
        reqValid = 1'b1;
        case (s_r.op)
          OP_READ:  req.data = `CMD_READ0;
          OP_PROG:  req.data = `CMD_SERIAL_IN;
          OP_ERASE: req.data = `CMD_ERASE_SET;
          OP_ID:    req.data = `CMD_READ_ID;
          default:  req.data = `CMD_RESET;
        endcase
      end
      S_ADDR:
      begin
        reqValid = 1'b1;
        req.kind = CK_ADDR;
        // Id mode takes a fixed zero address byte
        if (s_r.op != OP_ID)
          req.data = (s_r.aIdx == 2'd0) ? s_r.addr[7:0] :
                     (s_r.aIdx == 2'd1) ? s_r.addr[15:8] :
                     s_r.addr[23:16];
      end
      S_DATA:
      begin
        reqValid = s_r.wFull;
        req.kind = CK_WDATA;
        req.data = s_r.wByte;
      end
      S_CMD2:
      begin
        reqValid = 1'b1;
        req.data = (s_r.op == OP_PROG) ? `CMD_PROG_GO : `CMD_ERASE_GO;
      end
      S_STCMD:
      begin
        reqValid = 1'b1;
        req.data = `CMD_STATUS;
      end
      S_STRD, S_RDATA:
      begin
        // Page reads stall while software has not drained the last byte
        reqValid = !s_r.pend && (s_r.st == S_STRD || s_r.op == OP_ID ||
                                 !s_r.rFull);
        req.kind = CK_RDATA;
      end
      default: reqValid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register slave and operation sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rbMeta = readyIn;
    s_nxt.rbSync = s_r.rbMeta;
    // Write channel: address and data taken together
    if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;
    if (awTake)
    begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'b00;
      // Only byte lane 0 gates writes; other lanes follow it
      if (!wstrb[0])
        s_nxt.bresp = 2'b00;
      else if (awaddr == `REG_CMD)
      begin
        if (busy || wdata[`F_OP_MSB:0] > 3'(OP_RESET))
          s_nxt.bresp = 2'b10;
        else
        begin
          s_nxt.op = op_kind_t'(wdata[`F_OP_MSB:0]);
          s_nxt.len = wdata[`F_LEN_MSB:`F_LEN_LSB];
          s_nxt.cnt = 12'h000;
          s_nxt.st = (wdata[`F_OP_MSB:0] == 3'(OP_STATUS)) ? S_STCMD :
                     (wdata[`F_OP_MSB:0] == 3'(OP_RESET)) ? S_CMD1 :
                     S_READY;
        end
      end
      else if (awaddr == `REG_ADDR)
        s_nxt.addr = wdata[23:0];
      else if (awaddr == `REG_WDATA && !s_r.wFull)
      begin
        s_nxt.wByte = wdata[7:0];
        s_nxt.wFull = 1'b1;
      end
      else if (awaddr == `REG_CFG)
        s_nxt.wpRelease = wdata[0];
      else
        s_nxt.bresp = 2'b10;
    end
    // Read channel: answer one cycle after the address
    if (s_r.rvalid && rready)
      s_nxt.rvalid = 1'b0;
    if (!s_r.rvalid && arvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = 2'b00;
      case (araddr)
        `REG_CMD:    s_nxt.rdata = {28'h0, busy, s_r.op};
        `REG_ADDR:   s_nxt.rdata = {8'h00, s_r.addr};
        `REG_RDATA:
        begin
          s_nxt.rdata = {23'h0, s_r.rFull, s_r.rByte};
          s_nxt.rFull = 1'b0;
        end
        `REG_STATUS: s_nxt.rdata = {s_r.idDevice, s_r.idMaker,
                                    s_r.statusByte, 5'h00, s_r.rFull,
                                    s_r.st == S_DATA && !s_r.wFull, busy};
        `REG_CFG:    s_nxt.rdata = {31'h0, s_r.wpRelease};
        default:
        begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = 2'b10;
        end
      endcase
    end
    // Helpers that track what the card last latched
    if (fire && req.kind == CK_CMD)
    begin
      s_nxt.lastCmd = req.data;
      s_nxt.addrSeen = 2'd0;
    end
    if (fire && req.kind == CK_ADDR && s_r.addrSeen != 2'd3)
      s_nxt.addrSeen = s_r.addrSeen + 2'd1;
    if (fire && req.kind == CK_RDATA)
      s_nxt.pend = 1'b1;
    // Sequencer; it runs after the bus so a fill beats a drain
    unique case (s_r.st)
      // Idle holds; a command write above is what starts an operation,
      // so nothing here may overwrite the state it chose
      S_IDLE: ;
      // No new command until the card shows ready
      S_READY: if (s_r.rbSync) s_nxt.st = S_CMD1;
      S_CMD1:
        if (fire)
        begin
          s_nxt.aIdx = (s_r.op == OP_ERASE) ? 2'd1 : 2'd0;
          s_nxt.cnt = 12'h000;
          s_nxt.st = (s_r.op == OP_RESET) ? S_WB : S_ADDR;
        end
      S_ADDR:
        if (fire)
        begin
          s_nxt.aIdx = s_r.aIdx + 2'd1;
          if (s_r.op == OP_ID)
            s_nxt.st = S_RDATA;
          else if (s_r.aIdx == 2'd2)
            s_nxt.st = (s_r.op == OP_READ) ? S_WB :
                       (s_r.op == OP_ERASE || s_r.len == 12'h000) ?
                       S_CMD2 : S_DATA;
        end
      S_DATA:
        if (fire)
        begin
          s_nxt.wFull = 1'b0;
          s_nxt.cnt = s_r.cnt + 12'h001;
          if (s_r.cnt + 12'h001 == s_r.len)
            s_nxt.st = S_CMD2;
        end
      S_CMD2:
        if (fire)
        begin
          s_nxt.cnt = 12'h000;
          s_nxt.st = S_WB;
        end
      // Give the card time to pull its ready line low
      S_WB:
      begin
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.cnt == 12'(`T_WB_CYC - 1))
          s_nxt.st = S_BUSY;
      end
      S_BUSY:
        if (s_r.rbSync)
        begin
          s_nxt.cnt = 12'h000;
          if (s_r.op == OP_READ)
            s_nxt.st = (s_r.len == 12'h000) ? S_IDLE : S_RDATA;
          else if (s_r.op == OP_RESET)
            s_nxt.st = S_IDLE;
          else
            s_nxt.st = S_STCMD;
        end
      S_STCMD: if (fire) s_nxt.st = S_STRD;
      S_STRD:
        if (rdDone)
        begin
          s_nxt.pend = 1'b0;
          s_nxt.statusByte = rdByte;
          s_nxt.st = S_IDLE;
        end
      S_RDATA:
        if (rdDone)
        begin
          s_nxt.pend = 1'b0;
          s_nxt.cnt = s_r.cnt + 12'h001;
          if (s_r.op == OP_ID)
          begin
            if (s_r.cnt == 12'h000)
              s_nxt.idMaker = rdByte;
            else
            begin
              s_nxt.idDevice = rdByte;
              s_nxt.st = S_IDLE;
            end
          end
          else
          begin
            s_nxt.rByte = rdByte;
            s_nxt.rFull = 1'b1;
            if (s_r.cnt + 12'h001 == s_r.len)
              s_nxt.st = S_IDLE;
          end
        end
    endcase
  end

  // State register; write protect stays asserted after reset
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.rbMeta <= 1'b1;
      s_r.rbSync <= 1'b1;
      s_r.statusByte <= `STATUS_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;

  // Strobe engine and pin registers
  nand_cycle u_cycle (
    .clock     (clock),
    .rst_b     (rst_b),
    .reqValid  (reqValid),
    .req       (req),
    .reqReady  (reqReady),
    .wpRelease (s_r.wpRelease),
    .rdValid   (rdDone),
    .rdByte    (rdByte),
    .pins      (nandOut),
    .ioIn      (ioIn)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_prog_after_load: assert property (
    fire && req.kind == CK_CMD && req.data == `CMD_PROG_GO |->
      s_r.lastCmd == `CMD_SERIAL_IN && s_r.addrSeen == 2'd3)
    else $error("program confirm without serial input setup");
  a_busy_hold_ready: assert property (
    s_r.st == S_BUSY && !s_r.rbSync |=> s_r.st == S_BUSY)
    else $error("left busy wait while card busy");
  a_done_to_status: assert property (
    s_r.st == S_BUSY && s_r.rbSync && s_r.op == OP_PROG |=>
      s_r.st == S_STCMD ##1 s_r.st == S_STRD)
    else $error("no status read after program done");
  a_erase_two_addr: assert property (
    fire && req.kind == CK_CMD && req.data == `CMD_ERASE_GO |->
      s_r.lastCmd == `CMD_ERASE_SET && s_r.addrSeen == 2'd2)
    else $error("erase confirm without two block bytes");
  a_read_reissue: assert property (
    fire && req.kind == CK_RDATA && s_r.op == OP_READ |->
      s_r.lastCmd == `CMD_READ0)
    else $error("page read after other command");
  a_id_zero_addr: assert property (
    fire && req.kind == CK_ADDR && s_r.lastCmd == `CMD_READ_ID |->
      req.data == 8'h00 ##1 s_r.st == S_RDATA)
    else $error("id address byte not zero");
  a_wp_held_low: assert property (
    !s_r.wpRelease [*2] |-> !nandOut.writeProtectLow)
    else $error("write protect released without software");
  a_read_three_addr: assert property (
    fire && req.kind == CK_RDATA && s_r.op == OP_READ |->
      s_r.addrSeen == 2'd3)
    else $error("page read without three address bytes");
  a_cmd_wait_ready: assert property (
    fire && req.kind == CK_CMD && req.data != `CMD_STATUS &&
    req.data != `CMD_RESET |-> $past(s_r.rbSync))
    else $error("command issued while card busy");

  c_prog_done: cover property (
    s_r.op == OP_PROG && s_r.st == S_STRD ##[1:40] s_r.st == S_IDLE);
  c_erase_done: cover property (
    s_r.op == OP_ERASE && s_r.st == S_STRD ##[1:40] s_r.st == S_IDLE);
  c_id_read: cover property (
    s_r.op == OP_ID && rdDone && s_r.cnt == 12'h001);

endmodule : nand_host
`default_nettype wire

// [nand_card_model.sv]
`timescale 1ns/1ns
`default_nettype none

module nand_card_model
  import nand_host_pkg::*;
#(
  parameter logic [7:0] MAKER  = 8'h5a, // Arbitrary code
  parameter logic [7:0] DEVICE = 8'ha5  // Arbitrary code
)
(
  // Clock and host pins
  input  wire logic      clock,
  input  wire nand_out_t pins,
  // Card side of the wires
  output logic [7:0]     ioDrv,
  output logic           ioOe,
  output logic           readyOut,
  output logic [10:0]    lastBlock
);
  logic [7:0] page [16];
  logic [7:0] mode    = 8'h00; // Page read after power-up
  logic [7:0] busyCnt = 8'h00;
  logic [7:0] a0      = 8'h00;
  logic [3:0] col     = 4'h0;
  logic       aIdx    = 1'b0;
  logic       idIdx   = 1'b0;
  logic       loaded  = 1'b0;
  logic       inRst   = 1'b0;
  logic       weOld   = 1'b1;
  logic       reOld   = 1'b1;
  wire        sel     = !pins.chipEnableLow;
  wire  [7:0] io      = pins.ioOut;
  wire        we      = sel && pins.writeStrobeLow && !weOld;
  // Live status, refreshed without a new strobe
  wire  [7:0] stat    = {pins.writeProtectLow, readyOut, 6'h00};
  assign readyOut = busyCnt == 8'h00;
  assign ioOe     = sel && !pins.readStrobeLow;
  assign ioDrv    = mode == 8'h70 ? stat : mode == 8'h90 ?
                    (idIdx ? DEVICE : MAKER) : page[col];
  initial foreach (page[i]) page[i] = 8'hff;

  // Strobe edges seen on the clock; only 70H and FFH pass while busy
  always @(posedge clock)
  begin
    weOld <= pins.writeStrobeLow;
    reOld <= pins.readStrobeLow;
    if (!readyOut)
      busyCnt <= busyCnt - 8'h01;
    else
      inRst <= 1'b0;
    if (we && pins.cle && (readyOut || io == 8'h70 || io == 8'hff))
    begin
      aIdx <= 1'b0;
      idIdx <= 1'b0;
      mode <= io;
      if (io == 8'h80)
        loaded <= 1'b0;
      if (io == 8'h10 || io == 8'hd0)
        mode <= 8'h70;
      if ((io == 8'h10 && loaded) || (io == 8'hd0 && mode == 8'h60))
        busyCnt <= 8'd40; // Starts at this rising edge
      if (io == 8'hd0 && mode == 8'h60)
        foreach (page[i]) page[i] <= 8'hff;
      if (io == 8'hff)
        mode <= 8'hff; // Idle, waiting for a command
      if (io == 8'hff && !inRst)
        busyCnt <= 8'd20; // Second reset ignored
      if (io == 8'hff)
        inRst <= 1'b1;
    end
    if (we && pins.ale)
    begin
      aIdx <= 1'b1;
      if (!aIdx)
        a0 <= io;
      if (!aIdx)
        col <= io[3:0];
      if (aIdx && mode == 8'h60)
        lastBlock <= {io, a0[7:5]}; // A9..A13 dropped
      if (mode == 8'h00)
        busyCnt <= 8'd30; // Random read
    end
    if (we && !pins.cle && !pins.ale && mode == 8'h80)
    begin
      page[col] <= page[col] & io; // Partial load
      col <= col + 4'h1;
      loaded <= 1'b1;
    end
    if (sel && pins.readStrobeLow && !reOld)
    begin
      idIdx <= 1'b1;
      if (mode == 8'h00)
        col <= col + 4'h1;
    end
  end
endmodule : nand_card_model

`default_nettype wire

// [tb_nand_host.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_nand_host;
  import nand_host_pkg::*;
  localparam logic [7:0] MAKER  = 8'h3e; // Arbitrary code
  localparam logic [7:0] DEVICE = 8'hc7; // Arbitrary code
  logic        clock   = 1'b0;
  logic        rst_b   = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ioOe, readyIn;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  nand_out_t   nandOut;
  logic [7:0]  ioIn, ioDrv;
  logic [7:0]  lastIo  = 8'h00;
  logic [10:0] lastBlock;
  int          num_errors  = 0;
  int          check_count = 0;

  always #2 clock = ~clock;
  // Released wire shows the inverse of its last level
  assign ioIn = nandOut.ioOe ? nandOut.ioOut : ioOe ? ioDrv : ~lastIo;
  always @(posedge clock) lastIo <= ioIn;

  nand_host i_dut (.clock(clock), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .nandOut(nandOut), .ioIn(ioIn), .readyIn(readyIn));
  nand_card_model #(.MAKER(MAKER), .DEVICE(DEVICE)) i_card (.clock(clock),
    .pins(nandOut), .ioDrv(ioDrv), .ioOe(ioOe), .readyOut(readyIn),
    .lastBlock(lastBlock));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clock); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Poll until the controller leaves busy, bounded by the watchdog
  task automatic wait_idle(output logic [31:0] s);
    logic [1:0] r;
    do rd(8'h10, s, r); while (s[0] !== 1'b0);
  endtask : wait_idle

  task automatic run_op(input logic [31:0] c, output logic [31:0] s);
    logic [1:0] r;
    wr(8'h00, c, r);
    check(32'(r), 32'h0);
    wait_idle(s);
  endtask : run_op

  task automatic t_reset();
    logic [31:0] s;
    logic [1:0]  r;
    check(32'(nandOut), 32'h1c00);
    rd(8'h10, s, r);
    check(s[15:0], 32'hc000);
    rd(8'h20, s, r);
    check({s[29:0], r}, 32'h2);
  endtask : t_reset

  // Load two bytes at column 3, refuse a command while busy, read back
  task automatic t_program();
    logic [31:0] s;
    logic [1:0]  r;
    logic [7:0]  pat [2] = '{8'h5a, 8'h3c};
    wr(8'h14, 32'h1, r);
    wr(8'h04, 32'h3, r);
    wr(8'h00, 32'h21, r);
    for (int i = 0; i < 2; i++)
      do wr(8'h08, 32'(pat[i]), r); while (r !== 2'b00);
    wr(8'h00, 32'h3, r);
    check(32'(r), 32'h2);
    wait_idle(s);
    check(s[15:8], 32'hc0);
    check(32'(i_card.page[3]), 32'h5a);
    check(32'(i_card.page[5]), 32'hff);
    wr(8'h00, 32'h20, r);
    for (int i = 0; i < 2; i++)
    begin
      do rd(8'h0c, s, r); while (s[8] !== 1'b1);
      check(s[7:0], 32'(pat[i]));
    end
  endtask : t_program

  task automatic t_erase();
    logic [31:0] s;
    logic [1:0]  r;
    wr(8'h04, 32'h12ab00, r);
    run_op(32'h2, s);
    check(32'(lastBlock), 32'h095);
    check(32'(i_card.page[3]), 32'hff);
    check(s[15:8], 32'hc0);
  endtask : t_erase

  // Status with protect, identification, then card reset
  task automatic t_misc();
    logic [31:0] s;
    logic [1:0]  r;
    wr(8'h14, 32'h0, r);
    run_op(32'h3, s);
    check(s[15:8], 32'h40);
    wr(8'h14, 32'h1, r);
    run_op(32'h4, s);
    check(s[31:16], {16'h0, DEVICE, MAKER});
    run_op(32'h5, s);
    check(32'(i_card.mode), 32'hff);
    run_op(32'h3, s);
    check(s[15:8], 32'hc0);
  endtask : t_misc

  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset();
    t_program();
    t_erase();
    t_misc();
    complete_run();
  end

  // Watchdog, well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge clock);
    num_errors++;
    complete_run();
  end
endmodule : tb_nand_host

`default_nettype wire
